// File: pkg/prl_port2_defs.vh
// Constants for the second-port rate limit and cable diagnostic register bank.
// Assumes a 16-bit register port with byte addresses and one 20 MHz clock.
`ifndef PRL_PORT2_DEFS_VH
`define PRL_PORT2_DEFS_VH

// Register byte offsets.
`define PRL_OFS_ING_P1P0   8'h8c
`define PRL_OFS_ING_P3P2   8'h8e
`define PRL_OFS_EGR_P1P0   8'h90
`define PRL_OFS_EGR_P3P2   8'h92
`define PRL_OFS_CABLE_DIAG 8'h94

// Field positions.
`define PRL_HI_LIMIT       14:8
`define PRL_LO_LIMIT       6:0
`define PRL_BIT_EGR_EN     7
`define PRL_BIT_RSV_HI     15
`define PRL_BIT_RSV_LO     7
`define PRL_BIT_NEAR_SHORT 15
`define PRL_VERDICT        14:13
`define PRL_BIT_START      12
`define PRL_BIT_FORCE_LINK 11
`define PRL_BIT_RSV_DIAG   10
`define PRL_BIT_LOOPBACK   9
`define PRL_FAULT_COUNT    8:0

// Reset values.
`define PRL_RST_LIMIT      7'h00
`define PRL_RST_RSV        1'b0
`define PRL_RST_RSV_DIAG   1'b1
`define PRL_RST_VERDICT    2'h0
`define PRL_RST_COUNT      9'h000
`define PRL_RST_BUCKET     16'h0000
`define PRL_ZERO16         16'h0000

// Verdict encodings.
`define PRL_VERDICT_NORMAL 2'h0
`define PRL_VERDICT_OPEN   2'h1
`define PRL_VERDICT_SHORT  2'h2
`define PRL_VERDICT_FAIL   2'h3

// Credit refill: one tick per microsecond adds the limit code in bytes.
`define PRL_CLK_NS         50
`define PRL_TICK_NS        1000
`define PRL_TICK_CYC       (`PRL_TICK_NS / `PRL_CLK_NS)
`define PRL_TICK_W         5
`define PRL_BUCKET_MAX     16'h2000
`define PRL_NUM_BUCKETS    8
`define PRL_EGR_BASE       3'h4

`endif

// File: rtl/prl_port2_regs.v
// Register bank for the second switch port: rate limits and cable diagnostic.
// Assumes host and PHY logic run on sys_clk; the analog cable tester sits outside.
`timescale 1ns/1ns
`include "prl_port2_defs.vh"

// Overview of operation
// - Priority 0 ingress limit held in bits 6..0 of first ingress register.
// - Priority 3 ingress limit in bits 14..8 of second ingress register, resets zero.
// - Priority 2 ingress limit in bits 6..0 of second ingress register, resets zero.
// - A zero limit code means no limiting, full line rate.
// - Nonzero limit: frames beyond the configured rate are dropped.
// - Priority 1 egress limit held in bits 14..8 of first egress register.
// - Priority 0 egress limit held in bits 6..0 of first egress register.
// - Bit 7 of first egress register enables egress limiting, resets zero.
// - Second egress register holds priority 3 and priority 2 egress limits.
// - Writing one to bit 12 starts the cable test; hardware clears it when done.
// - Bits 14..13 report verdict: normal, open, short, failed.
// - Bit 15 flags a short closer than ten meters.
// - Bits 8..0 give the fault distance count, about 0.4 m per step.
// - Bit 11 forces the link indication to pass.
// - Bit 9 loops received line data back to the transmitter.
module prl_port2_regs (
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [1:0]  reg_be,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  input  wire        ing_req,
  input  wire [1:0]  ing_prio,
  input  wire [10:0] ing_len,
  output reg         ing_ack,
  output reg         ing_pass,
  input  wire        egr_req,
  input  wire [1:0]  egr_prio,
  input  wire [10:0] egr_len,
  output reg         egr_ack,
  output reg         egr_pass,
  output reg         cable_test_go,
  input  wire        cable_test_done,
  input  wire [1:0]  cable_test_result,
  input  wire        cable_test_near,
  input  wire [8:0]  cable_test_count,
  input  wire        phy_link_raw,
  output reg         link_ok,
  output reg         force_link,
  output reg         near_loopback
);

  // Saturating credit refill.
  function [15:0] credit_add;
    input [15:0] level;
    input [6:0]  code;
    reg   [16:0] sum;
    begin
      sum = {1'b0, level} + {10'h000, code};
      if (sum > {1'b0, `PRL_BUCKET_MAX})
        credit_add = `PRL_BUCKET_MAX;
      else
        credit_add = sum[15:0];
    end
  endfunction

  // True when a frame of len bytes may pass at this code and credit level.
  function frame_fits;
    input [15:0] level;
    input [6:0]  code;
    input [10:0] len;
    begin
      frame_fits = (code == `PRL_RST_LIMIT) || (level >= {5'h00, len});
    end
  endfunction

  // Byte-lane merge for a 16-bit register write.
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wdat;
    input [1:0]  be;
    begin
      lane_merge[15:8] = be[1] ? wdat[15:8] : old[15:8];
      lane_merge[7:0]  = be[0] ? wdat[7:0]  : old[7:0];
    end
  endfunction

  reg  [15:0] ing_p1p0;
  reg  [15:0] ing_p3p2;
  reg  [15:0] egr_p1p0;
  reg  [15:0] egr_p3p2;
  reg         near_short_flag;
  reg  [1:0]  cable_test_verdict;
  reg         cable_test_start;
  reg         diag_rsv;
  reg  [8:0]  fault_distance_count;
  reg  [`PRL_TICK_W-1:0] tick_cnt;
  reg         tick;
  reg  [15:0] bucket [0:`PRL_NUM_BUCKETS-1];
  reg  [15:0] next_bucket [0:`PRL_NUM_BUCKETS-1];
  wire [6:0]  code [0:`PRL_NUM_BUCKETS-1];
  wire [15:0] diag_word;
  wire [15:0] diag_merged;
  wire        wr_diag;
  wire        start_req;
  wire [2:0]  ing_idx;
  wire [2:0]  egr_idx;
  wire        ing_fit;
  wire        egr_fit;
  integer     i;

  assign code[0] = ing_p1p0[`PRL_LO_LIMIT];
  assign code[1] = ing_p1p0[`PRL_HI_LIMIT];
  assign code[2] = ing_p3p2[`PRL_LO_LIMIT];
  assign code[3] = ing_p3p2[`PRL_HI_LIMIT];
  assign code[4] = egr_p1p0[`PRL_BIT_EGR_EN] ? egr_p1p0[`PRL_LO_LIMIT] : `PRL_RST_LIMIT;
  assign code[5] = egr_p1p0[`PRL_BIT_EGR_EN] ? egr_p1p0[`PRL_HI_LIMIT] : `PRL_RST_LIMIT;
  assign code[6] = egr_p1p0[`PRL_BIT_EGR_EN] ? egr_p3p2[`PRL_LO_LIMIT] : `PRL_RST_LIMIT;
  assign code[7] = egr_p1p0[`PRL_BIT_EGR_EN] ? egr_p3p2[`PRL_HI_LIMIT] : `PRL_RST_LIMIT;

  assign ing_idx = {1'b0, ing_prio};
  assign egr_idx = `PRL_EGR_BASE + {1'b0, egr_prio};
  assign ing_fit = frame_fits(bucket[ing_idx], code[ing_idx], ing_len);
  assign egr_fit = frame_fits(bucket[egr_idx], code[egr_idx], egr_len);

  assign diag_word = {near_short_flag, cable_test_verdict, cable_test_start, force_link,
                      diag_rsv, near_loopback, fault_distance_count};
  assign diag_merged = lane_merge(diag_word, reg_wdata, reg_be);
  assign wr_diag = reg_wr && (reg_addr == `PRL_OFS_CABLE_DIAG);
  assign start_req = wr_diag && diag_merged[`PRL_BIT_START] && !cable_test_start;

  // Microsecond refill tick.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      tick_cnt <= {`PRL_TICK_W{1'b0}};
      tick     <= 1'b0;
    end else if (tick_cnt == `PRL_TICK_CYC - 1) begin
      tick_cnt <= {`PRL_TICK_W{1'b0}};
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  always @* begin
    for (i = 0; i < `PRL_NUM_BUCKETS; i = i + 1) begin
      next_bucket[i] = bucket[i];
      if (tick)
        next_bucket[i] = credit_add(next_bucket[i], code[i]);
      if (ing_req && ing_fit && (ing_idx == i) && (code[i] != `PRL_RST_LIMIT))
        next_bucket[i] = next_bucket[i] - {5'h00, ing_len};
      if (egr_req && egr_fit && (egr_idx == i) && (code[i] != `PRL_RST_LIMIT))
        next_bucket[i] = next_bucket[i] - {5'h00, egr_len};
      // A dormant bucket is kept empty so enabling a limit starts clean.
      if (code[i] == `PRL_RST_LIMIT)
        next_bucket[i] = `PRL_RST_BUCKET;
    end
  end

  always @(posedge sys_clk) begin
    for (i = 0; i < `PRL_NUM_BUCKETS; i = i + 1) begin
      if (!nrst)
        bucket[i] <= `PRL_RST_BUCKET;
      else
        bucket[i] <= next_bucket[i];
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      ing_ack  <= 1'b0;
      ing_pass <= 1'b0;
      egr_ack  <= 1'b0;
      egr_pass <= 1'b0;
    end else begin
      ing_ack  <= ing_req;
      ing_pass <= ing_req && ing_fit;
      egr_ack  <= egr_req;
      egr_pass <= egr_req && egr_fit;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      ing_p1p0 <= `PRL_ZERO16;
      ing_p3p2 <= `PRL_ZERO16;
      egr_p1p0 <= `PRL_ZERO16;
      egr_p3p2 <= `PRL_ZERO16;
    end else if (reg_wr) begin
      case (reg_addr)
        `PRL_OFS_ING_P1P0: begin
          ing_p1p0 <= lane_merge(ing_p1p0, reg_wdata, reg_be);
        end
        `PRL_OFS_ING_P3P2: begin
          ing_p3p2 <= lane_merge(ing_p3p2, reg_wdata, reg_be);
        end
        `PRL_OFS_EGR_P1P0: begin
          egr_p1p0 <= lane_merge(egr_p1p0, reg_wdata, reg_be);
        end
        `PRL_OFS_EGR_P3P2: begin
          egr_p3p2 <= lane_merge(egr_p3p2, reg_wdata, reg_be);
        end
        default: begin
        end
      endcase
    end
  end

  // Diagnostic control bits and the reserved bit that resets high.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      force_link    <= 1'b0;
      near_loopback <= 1'b0;
      diag_rsv      <= `PRL_RST_RSV_DIAG;
    end else if (wr_diag) begin
      force_link    <= diag_merged[`PRL_BIT_FORCE_LINK];
      near_loopback <= diag_merged[`PRL_BIT_LOOPBACK];
      diag_rsv      <= diag_merged[`PRL_BIT_RSV_DIAG];
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst)
      link_ok <= 1'b0;
    else
      link_ok <= phy_link_raw || force_link;
  end

  // The start bit cannot be cleared by software; a running test always finishes,
  // which keeps the result fields from being torn by an abort.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cable_test_start <= 1'b0;
      cable_test_go    <= 1'b0;
    end else begin
      cable_test_go <= start_req;
      if (start_req)
        cable_test_start <= 1'b1;
      else if (cable_test_done)
        cable_test_start <= 1'b0;
    end
  end

  // Results are captured only at completion, so they stay stable for reading.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      near_short_flag      <= 1'b0;
      cable_test_verdict   <= `PRL_RST_VERDICT;
      fault_distance_count <= `PRL_RST_COUNT;
    end else if (cable_test_done && cable_test_start) begin
      near_short_flag      <= cable_test_near;
      cable_test_verdict   <= cable_test_result;
      fault_distance_count <= cable_test_count;
    end
  end

  // Read port: data one cycle after the strobe; unmapped offsets read zero.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata  <= `PRL_ZERO16;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `PRL_OFS_ING_P1P0:   reg_rdata <= ing_p1p0;
          `PRL_OFS_ING_P3P2:   reg_rdata <= ing_p3p2;
          `PRL_OFS_EGR_P1P0:   reg_rdata <= egr_p1p0;
          `PRL_OFS_EGR_P3P2:   reg_rdata <= egr_p3p2;
          `PRL_OFS_CABLE_DIAG: reg_rdata <= diag_word;
          default:             reg_rdata <= `PRL_ZERO16;
        endcase
      end
    end
  end

endmodule

// File: test/prl_cable_model.sv
// Far-side cable tester model: answers each start pulse with one done pulse unless set_wait is zero.
// Assumes it shares sys_clk with the register bank; the bench sets the results.
`timescale 1ns/1ns
module prl_cable_model (
  input  wire       sys_clk,
  input  wire       cable_test_go,
  input  wire [1:0] set_result,
  input  wire       set_near,
  input  wire [8:0] set_count,
  input  wire [7:0] set_wait,
  output reg        cable_test_done,
  output reg  [1:0] cable_test_result,
  output reg        cable_test_near,
  output reg  [8:0] cable_test_count
);
  integer wait_c = 0;
  initial {cable_test_done, cable_test_result, cable_test_near, cable_test_count} = 13'h0;
  // test completion
  // Results only mean something with done; they toggle otherwise so a late sample shows.
  always @(posedge sys_clk) begin
    cable_test_done <= wait_c == 1;
    if (cable_test_go)
      wait_c <= set_wait;
    else if (wait_c > 0)
      wait_c <= wait_c - 1;
    if (wait_c == 1)
      {cable_test_result, cable_test_near, cable_test_count} <= {set_result, set_near, set_count};
    else
      {cable_test_result, cable_test_near, cable_test_count} <=
        ~{cable_test_result, cable_test_near, cable_test_count};
  end
endmodule

// File: test/prl_port2_regs_asserts.sv
// Checker for the port-2 register bank: handshakes, test start, link outputs.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ns
`include "prl_port2_defs.vh"
module prl_port2_regs_asserts (
  input wire        sys_clk,
  input wire        nrst,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [1:0]  reg_be,
  input wire [15:0] reg_wdata,
  input wire        reg_rvalid,
  input wire        ing_req,
  input wire        ing_ack,
  input wire        ing_pass,
  input wire        egr_req,
  input wire        egr_ack,
  input wire        cable_test_go,
  input wire        phy_link_raw,
  input wire        link_ok,
  input wire        force_link,
  input wire        near_loopback
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire diag_hi = reg_wr && reg_addr == `PRL_OFS_CABLE_DIAG && reg_be[1];
  start_go_a: assert property (cable_test_go |-> $past(diag_hi && reg_wdata[`PRL_BIT_START]) ##1 !cable_test_go)
    else $error("start pulse wrong");
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  ing_answer_a: assert property (ing_req |=> ing_ack)
    else $error("ingress not answered");
  ing_qual_a: assert property ((ing_ack || ing_pass) |-> $past(ing_req))
    else $error("ingress answer unasked");
  egr_answer_a: assert property (egr_req |=> egr_ack)
    else $error("egress not answered");
  link_follow_a: assert property ($past(nrst) |-> link_ok == ($past(phy_link_raw) || $past(force_link)))
    else $error("link indication wrong");
  force_follow_a: assert property ($changed(force_link) |-> $past(diag_hi))
    else $error("force moved unwritten");
  loop_follow_a: assert property ($changed(near_loopback) |-> $past(diag_hi))
    else $error("loopback moved unwritten");
  cover property (cable_test_go);
  cover property (ing_ack && !ing_pass);
  cover property (egr_ack);
endmodule
bind prl_port2_regs prl_port2_regs_asserts chk_u (.*);

// File: test/prl_port2_regs_test.sv
// Self-checking bench for the port-2 register bank with a cable tester model.
// Assumes the bank, its constants header and the tester model are compiled first.
`timescale 1ns/1ns
module prl_port2_regs_test;
  reg         sys_clk, nrst, reg_wr, reg_rd, ing_req, egr_req, phy_link_raw, set_near;
  reg  [1:0]  reg_be, ing_prio, egr_prio, set_result;
  reg  [7:0]  reg_addr, set_wait;
  reg  [8:0]  set_count;
  reg  [10:0] ing_len, egr_len;
  reg  [15:0] reg_wdata, rv, mir [0:5];
  wire        reg_rvalid, ing_ack, ing_pass, egr_ack, egr_pass, cable_test_go, link_ok;
  wire        force_link, near_loopback, cable_test_done, cable_test_near;
  wire [1:0]  cable_test_result;
  wire [8:0]  cable_test_count;
  wire [15:0] reg_rdata;
  integer     fails = 0, compares = 0, seed = 31794, i, v;
  prl_port2_regs dut_u (.*);
  prl_cable_model far_u (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    phy_link_raw <= $random(seed);
  // The prediction is taken at the falling edge, where the inputs and the mirror
  // already hold what the next rising edge will sample, so no race with the tasks.
  reg lk_exp = 1'b0;
  reg lk_arm = 1'b0;
  always @(negedge sys_clk) begin
    if (lk_arm)
      chk({15'h0, link_ok}, {15'h0, lk_exp});
    lk_exp = nrst && (phy_link_raw || mir[4][11]);
    lk_arm = 1'b1;
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (fails == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task rst;
    begin
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      for (i = 0; i < 6; i = i + 1)
        mir[i] = (i == 4) ? 16'h0400 : 16'h0000;
    end
  endtask
  // The mirror keeps only host-writable bits; of the diagnostic word it keeps 11..9, not the self-clearing start bit 12.
  task wr16(input [7:0] a, input [1:0] b, input [15:0] d);
    reg [15:0] m;
    begin
      @(posedge sys_clk);
      {reg_addr, reg_be, reg_wdata, reg_wr} <= {a, b, d, 1'b1};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      m = {{8{b[1]}}, {8{b[0]}}} & ((a == 8'h94) ? 16'h0e00 : 16'hffff);
      if (a != 8'h96)
        mir[(a - 8'h8c) / 2] = (mir[(a - 8'h8c) / 2] & ~m) | (d & m);
    end
  endtask
  task rd16(input [7:0] a, output [15:0] d);
    begin
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk({15'h0, reg_rvalid}, 16'h0001);
    end
  endtask
  task rdc(input [7:0] a, input [15:0] e);
    begin
      rd16(a, rv);
      chk(rv, e);
    end
  endtask
  task frm(input e, input [1:0] p, input [10:0] l, input x);
    begin
      @(posedge sys_clk);
      {egr_req, ing_req, egr_prio, ing_prio, egr_len, ing_len} <= {e, !e, p, p, l, l};
      @(posedge sys_clk);
      {egr_req, ing_req} <= 2'b00;
      #1 chk({14'h0, e ? {egr_ack, egr_pass} : {ing_ack, ing_pass}}, {14'h0, 1'b1, x});
    end
  endtask
  initial begin
    {nrst, reg_wr, reg_rd, ing_req, egr_req, set_near} = 6'h0;
    {reg_addr, reg_be, reg_wdata, ing_prio, egr_prio, ing_len, egr_len} = 52'h0;
    {set_result, set_count, set_wait} = 19'h0;
    rst;
    for (i = 0; i < 6; i = i + 1)
      rdc(i[7:0] * 8'h02 + 8'h8c, mir[i]);
    for (v = 0; v < 40; v = v + 1) begin
      rv = $random(seed);
      i = {$random(seed)} % 6;
      wr16(i[7:0] * 8'h02 + 8'h8c, rv[13:12], rv & 16'hefff);
      rdc(i[7:0] * 8'h02 + 8'h8c, mir[i]);
      chk({14'h0, force_link, near_loopback}, {14'h0, mir[4][11], mir[4][9]});
    end
    for (i = 0; i < 4; i = i + 1)
      wr16(i[7:0] * 8'h02 + 8'h8c, 2'b11, 16'h0000);
    for (i = 0; i < 8; i = i + 1)
      frm(i[2], i[1:0], 11'h7ff, 1'b1);
    // Ten bytes per microsecond for 200 cycles leaves between 100 and 110 bytes.
    wr16(8'h8e, 2'b01, 16'h000a);
    repeat (200) @(posedge sys_clk);
    frm(1'b0, 2'd2, 11'd90, 1'b1);
    frm(1'b0, 2'd2, 11'd90, 1'b0);
    frm(1'b0, 2'd2, 11'd5, 1'b1);
    wr16(8'h92, 2'b10, 16'h0a00);
    repeat (40) @(posedge sys_clk);
    frm(1'b1, 2'd3, 11'h7ff, 1'b1);
    wr16(8'h90, 2'b01, 16'h0080);
    frm(1'b1, 2'd3, 11'd90, 1'b0);
    frm(1'b1, 2'd0, 11'd90, 1'b1);
    for (v = 0; v < 4; v = v + 1) begin
      rv = $random(seed);
      {set_result, set_near, set_count, set_wait} <= {v[1:0], v == 2, rv[8:0], v[0] ? 8'd60 : 8'd4};
      wr16(8'h94, 2'b10, mir[4] | 16'h1000);
      rdc(8'h94, mir[4] | 16'h1000);
      rv = 16'h1000;
      for (i = 0; i < 60 && rv[12]; i = i + 1)
        rd16(8'h94, rv);
      mir[4] = {v == 2, v[1:0], 1'b0, mir[4][11:9], set_count};
      chk(rv, mir[4]);
    end
    rst;
    rdc(8'h94, 16'h0400);
    rdc(8'h8e, 16'h0000);
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails = fails + 1;
    stop_test;
  end
endmodule
